// >>> rtl/quad_timer_pkg.sv
// constants for the four channel counter/timer
package quad_timer_pkg;
	// ------------------------------
	// control word fields
	// ------------------------------
	localparam int CW_IS_CONTROL = 0;
	localparam int CW_SOFT_RESET = 1;
	localparam int CW_CONST_FOLLOWS = 2;
	localparam int CW_EXT_TRIGGER = 3;
	localparam int CW_RISING_EDGE = 4;
	localparam int CW_PRESCALE_256 = 5;
	localparam int CW_COUNTER_MODE = 6;
	localparam int CW_INT_ENABLE = 7;
	// ------------------------------
	// sizes and codes
	// ------------------------------
	localparam int CHANNELS = 4;
	localparam int PIN_CHANNELS = 3;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] OPCODE_PREFIX = 8'hed;
	localparam logic [7:0] OPCODE_RETURN = 8'h4d;
	localparam logic [7:0] PRESCALE_16_LAST = 8'h0f;
	localparam logic [7:0] PRESCALE_256_LAST = 8'hff;
	localparam logic [7:0] VECTOR_KEEP_MASK = 8'hf8;
	localparam int VEC_CH_LSB = 1;
endpackage : quad_timer_pkg

// >>> rtl/quad_timer.sv
// four channel down-counting counter/timer with daisy-chain interrupt
//
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/1ns
module quad_timer (
	// clock and reset
	input wire logic mclk_in,
	input wire logic rst_n_in,
	// register port
	input wire logic [1:0] channel_select_in,
	input wire logic [7:0] wdata_in,
	input wire logic write_in,
	input wire logic read_in,
	output logic [7:0] rdata_out,
	// channel pins
	input wire logic [3:0] edge_input_in,
	output logic [2:0] zero_count_pulse_out,
	// interrupt chain
	input wire logic opcode_fetch_n_in,
	input wire logic io_request_n_in,
	input wire logic [7:0] fetch_data_in,
	input wire logic chain_priority_in,
	output logic chain_priority_out,
	output logic int_request_n_out,
	output logic [7:0] vector_out,
	output logic vector_valid_out
);
	// ------------------------------
	// per channel and shared state
	// ------------------------------
	logic [7:0] ctrl [quad_timer_pkg::CHANNELS];
	logic [7:0] tconst [quad_timer_pkg::CHANNELS];
	logic [7:0] count [quad_timer_pkg::CHANNELS];
	logic [7:0] prescale [quad_timer_pkg::CHANNELS];
	logic [3:0] const_pending;
	logic [3:0] running;
	logic [3:0] armed;
	logic [3:0] edge_prev;
	logic [3:0] zero_hit;
	logic [3:0] pending;
	logic [3:0] in_service;
	logic [7:0] vector_base;
	logic prefix_seen;
	logic fetch_prev;
	logic [3:0] trig_edge;
	logic [3:0] tick;
	logic ack;
	logic fetch_start;
	logic [3:0] next_service;
	logic [1:0] winner;
	logic win_found;
	logic write_const;
	logic write_ctrl;
	logic write_vector;

	// true when the word is a control word
	function automatic logic is_control(input logic [7:0] w);
		is_control = w[quad_timer_pkg::CW_IS_CONTROL];
	endfunction : is_control

	// true when the channel counts prescaler ticks
	function automatic logic is_timer(input logic [7:0] c);
		is_timer = !c[quad_timer_pkg::CW_COUNTER_MODE];
	endfunction : is_timer

	// true when a timer waits for its trigger edge
	function automatic logic waits_trigger(input logic [7:0] c);
		waits_trigger = is_timer(c) && c[quad_timer_pkg::CW_EXT_TRIGGER];
	endfunction : waits_trigger

	// ------------------------------
	// edge detection and prescaler ticks
	// ------------------------------
	always_comb begin
		for (int i = 0; i < quad_timer_pkg::CHANNELS; i++) begin
			// selected slope, one cycle of the clock per edge
			trig_edge[i] = ctrl[i][quad_timer_pkg::CW_RISING_EDGE] ?
				(edge_input_in[i] & ~edge_prev[i]) : (~edge_input_in[i] & edge_prev[i]);
			// prescaler terminal value by bit 5
			if (ctrl[i][quad_timer_pkg::CW_COUNTER_MODE]) begin
				tick[i] = trig_edge[i];
			end else if (ctrl[i][quad_timer_pkg::CW_PRESCALE_256]) begin
				tick[i] = prescale[i] == quad_timer_pkg::PRESCALE_256_LAST;
			end else begin
				tick[i] = prescale[i] == quad_timer_pkg::PRESCALE_16_LAST;
			end
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			edge_prev <= edge_input_in;
		end else begin
			edge_prev <= edge_input_in;
		end
	end

	// ------------------------------
	// write decoding
	// ------------------------------
	// one channel per write, chosen by select code
	assign write_const = write_in && const_pending[channel_select_in];
	assign write_ctrl = write_in && !const_pending[channel_select_in] && is_control(wdata_in);
	assign write_vector = write_in && !const_pending[channel_select_in] && !is_control(wdata_in)
		&& channel_select_in == 2'b00;

	// ------------------------------
	// programming
	// ------------------------------
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			vector_base <= 8'h00;
		end else if (write_vector) begin
			// keep only the upper vector bits
			vector_base <= wdata_in & quad_timer_pkg::VECTOR_KEEP_MASK;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			const_pending <= 4'h0;
			for (int i = 0; i < quad_timer_pkg::CHANNELS; i++) begin
				ctrl[i] <= quad_timer_pkg::CTRL_RESET;
			end
		end else if (write_const) begin
			const_pending[channel_select_in] <= 1'b0;
		end else if (write_ctrl) begin
			ctrl[channel_select_in] <= wdata_in;
			const_pending[channel_select_in] <= wdata_in[quad_timer_pkg::CW_CONST_FOLLOWS];
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			for (int i = 0; i < quad_timer_pkg::CHANNELS; i++) begin
				tconst[i] <= 8'h00;
			end
		end else if (write_const) begin
			tconst[channel_select_in] <= wdata_in;
		end
	end

	// ------------------------------
	// start, trigger and software reset
	// ------------------------------
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			running <= 4'h0;
			armed <= 4'h0;
		end else begin
			for (int i = 0; i < quad_timer_pkg::CHANNELS; i++) begin
				if (armed[i] && trig_edge[i]) begin
					armed[i] <= 1'b0;
					running[i] <= 1'b1;
				end
			end
			if (write_const && !running[channel_select_in]) begin
				if (waits_trigger(ctrl[channel_select_in])) begin
					armed[channel_select_in] <= 1'b1;
				end else begin
					running[channel_select_in] <= 1'b1;
				end
			end else if (write_ctrl && wdata_in[quad_timer_pkg::CW_SOFT_RESET]) begin
				// software reset stops until new constant
				running[channel_select_in] <= 1'b0;
				armed[channel_select_in] <= 1'b0;
			end
		end
	end

	// ------------------------------
	// prescaler and down-counter
	// ------------------------------
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			for (int i = 0; i < quad_timer_pkg::CHANNELS; i++) begin
				prescale[i] <= 8'h00;
			end
		end else begin
			for (int i = 0; i < quad_timer_pkg::CHANNELS; i++) begin
				// free prescaler while the timer runs
				if (armed[i] && trig_edge[i]) begin
					prescale[i] <= 8'h00;
				end else if (running[i] && is_timer(ctrl[i])) begin
					prescale[i] <= tick[i] ? 8'h00 : prescale[i] + 8'h01;
				end
			end
			if (write_const && !running[channel_select_in]) begin
				prescale[channel_select_in] <= 8'h00;
			end
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			zero_hit <= 4'h0;
			for (int i = 0; i < quad_timer_pkg::CHANNELS; i++) begin
				count[i] <= 8'h00;
			end
		end else begin
			zero_hit <= 4'h0;
			for (int i = 0; i < quad_timer_pkg::CHANNELS; i++) begin
				if (running[i] && tick[i]) begin
					// zero stored counts as 256 by wrap of the 8-bit counter
					if (count[i] == 8'h01) begin
						count[i] <= tconst[i];
						zero_hit[i] <= 1'b1;
					end else begin
						count[i] <= count[i] - 8'h01;
					end
				end
			end
			if (write_const && !running[channel_select_in]) begin
				count[channel_select_in] <= wdata_in;
			end
		end
	end

	// ------------------------------
	// count readback
	// ------------------------------
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			rdata_out <= 8'h00;
		end else if (read_in) begin
			rdata_out <= count[channel_select_in];
		end else begin
			rdata_out <= 8'h00;
		end
	end

	// ------------------------------
	// zero count pins
	// ------------------------------
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			zero_count_pulse_out <= 3'h0;
		end else begin
			zero_count_pulse_out <= zero_hit[quad_timer_pkg::PIN_CHANNELS-1:0];
		end
	end

	// ------------------------------
	// interrupt chain
	// ------------------------------
	assign ack = !opcode_fetch_n_in && !io_request_n_in;
	assign fetch_start = !opcode_fetch_n_in && fetch_prev && io_request_n_in;

	always_comb begin
		winner = 2'b00;
		win_found = 1'b0;
		for (int i = quad_timer_pkg::CHANNELS - 1; i >= 0; i--) begin
			if (pending[i]) begin
				winner = 2'(i);
				win_found = 1'b1;
			end
		end
	end

	always_comb begin
		next_service = in_service;
		for (int i = 0; i < quad_timer_pkg::CHANNELS; i++) begin
			if (i == int'(winner) && win_found && ack && chain_priority_in && in_service == 4'h0) begin
				next_service[i] = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			pending <= 4'h0;
			in_service <= 4'h0;
			prefix_seen <= 1'b0;
			fetch_prev <= 1'b1;
			vector_out <= 8'h00;
			vector_valid_out <= 1'b0;
		end else begin
			fetch_prev <= opcode_fetch_n_in;
			for (int i = 0; i < quad_timer_pkg::CHANNELS; i++) begin
				// set wins over the acknowledge clear
				if (zero_hit[i] && ctrl[i][quad_timer_pkg::CW_INT_ENABLE]) begin
					pending[i] <= 1'b1;
				end else if (next_service[i] && !in_service[i]) begin
					pending[i] <= 1'b0;
				end
			end
			in_service <= next_service;
			vector_valid_out <= 1'b0;
			if (ack && chain_priority_in && win_found && in_service == 4'h0) begin
				vector_out <= vector_base | {5'h00, winner, 1'b0};
				vector_valid_out <= 1'b1;
			end
			if (fetch_start) begin
				if (prefix_seen && fetch_data_in == quad_timer_pkg::OPCODE_RETURN && chain_priority_in) begin
					in_service <= 4'h0;
				end
				prefix_seen <= fetch_data_in == quad_timer_pkg::OPCODE_PREFIX;
			end
		end
	end

	always_comb begin
		if (!chain_priority_in || in_service != 4'h0) begin
			chain_priority_out = 1'b0;
		end else if (pending != 4'h0) begin
			chain_priority_out = prefix_seen;
		end else begin
			chain_priority_out = 1'b1;
		end
	end

	assign int_request_n_out = !(pending != 4'h0 && chain_priority_in && in_service == 4'h0);
endmodule : quad_timer

// >>> verification/quad_timer_props.sv
// port assertions for the four channel counter/timer
`timescale 1ns/1ns
module quad_timer_props (
	// clock and reset
	input wire logic mclk_in,
	input wire logic rst_n_in,
	// register port
	input wire logic [1:0] channel_select_in,
	input wire logic [7:0] wdata_in,
	input wire logic write_in,
	input wire logic read_in,
	input wire logic [7:0] rdata_out,
	// channel pins
	input wire logic [3:0] edge_input_in,
	input wire logic [2:0] zero_count_pulse_out,
	// interrupt chain
	input wire logic opcode_fetch_n_in,
	input wire logic io_request_n_in,
	input wire logic [7:0] fetch_data_in,
	input wire logic chain_priority_in,
	input wire logic chain_priority_out,
	input wire logic int_request_n_out,
	input wire logic [7:0] vector_out,
	input wire logic vector_valid_out
);
	logic fetch_q;
	logic ed_seen;
	// tracks whether the last decoded fetch byte was the return prefix
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			fetch_q <= 1'b1;
			ed_seen <= 1'b0;
		end else begin
			fetch_q <= opcode_fetch_n_in;
			if (!opcode_fetch_n_in && fetch_q && io_request_n_in) begin
				ed_seen <= fetch_data_in == 8'hed;
			end
		end
	end
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);
	a_int_needs_chain: assert property (!chain_priority_in |-> int_request_n_out) else $error("int without chain");
	a_chain_in_low: assert property (!chain_priority_in |-> !chain_priority_out) else $error("chain out high");
	a_int_drops_chain: assert property ((!int_request_n_out && !ed_seen) |-> !chain_priority_out) else $error("chain not low");
	a_prefix_lifts_chain: assert property ((!int_request_n_out && ed_seen) |-> chain_priority_out) else $error("chain not raised");
	a_valid_after_ack: assert property (vector_valid_out |-> $past(!opcode_fetch_n_in && !io_request_n_in
		&& chain_priority_in && !int_request_n_out)) else $error("vector without ack");
	a_valid_one_pulse: assert property (vector_valid_out |=> !vector_valid_out [*2]) else $error("valid too long");
	a_vector_holds: assert property (!vector_valid_out |-> $stable(vector_out)) else $error("vector moved");
	a_read_idle_zero: assert property (!$past(read_in) |-> rdata_out == 8'h00) else $error("rdata not zero");
	a_pulse_one_cycle: assert property (|zero_count_pulse_out |=>
		(zero_count_pulse_out & $past(zero_count_pulse_out)) == 3'h0) else $error("pulse too long");
endmodule : quad_timer_props

// >>> verification/quad_timer_host.sv
// host model for interrupt acknowledge and return fetches
`timescale 1ns/1ns
module quad_timer_host (
	// clock and answer
	input wire logic mclk_in,
	input wire logic [7:0] vector_in,
	input wire logic valid_in,
	// fetch strobes
	output logic fetch_n_out,
	output logic io_n_out,
	output logic [7:0] data_out
);
	initial begin
		fetch_n_out = 1'b1;
		io_n_out = 1'b1;
		data_out = 8'h00;
	end
	task automatic ack(output logic ok, output logic [7:0] vec);
		@(posedge mclk_in);
		fetch_n_out <= 1'b0;
		data_out <= 8'h00;
		@(posedge mclk_in);
		io_n_out <= 1'b0;
		@(posedge mclk_in);
		fetch_n_out <= 1'b1;
		io_n_out <= 1'b1;
		#1;
		ok = valid_in;
		vec = vector_in;
	endtask : ack
	task automatic fetch(logic [7:0] b);
		@(posedge mclk_in);
		fetch_n_out <= 1'b0;
		data_out <= b;
		@(posedge mclk_in);
		fetch_n_out <= 1'b1;
		data_out <= ~b;
	endtask : fetch
endmodule : quad_timer_host

// >>> verification/four_channel_counter_timer_tb_top.sv
// self-checking bench for the four channel counter/timer
`timescale 1ns/1ns
module four_channel_counter_timer_tb_top;
	logic mclk_in = 1'b0, rst_n_in = 1'b0, write_in = 1'b0, read_in = 1'b0, chain_priority_in = 1'b1;
	logic [1:0] channel_select_in = 2'h0, c;
	logic [7:0] wdata_in = 8'h00, rdata_out, fetch_data_in, vector_out, v, tc, ctl;
	logic [3:0] edge_input_in = 4'h0;
	logic [2:0] zero_count_pulse_out;
	logic opcode_fetch_n_in, io_request_n_in, chain_priority_out, int_request_n_out, vector_valid_out, ok;
	logic [15:0] n;
	int errors = 0, n_checks = 0, np1 = 0;
	quad_timer i_dut (.*);
	quad_timer_host i_host (.mclk_in(mclk_in), .vector_in(vector_out), .valid_in(vector_valid_out),
		.fetch_n_out(opcode_fetch_n_in), .io_n_out(io_request_n_in), .data_out(fetch_data_in));
	initial forever #50 mclk_in = ~mclk_in;
	always @(posedge mclk_in) if (zero_count_pulse_out[1] === 1'b1) np1++;
	function automatic logic [15:0] period(logic [7:0] k, logic [7:0] t);
		return (k[5] ? 16'h0100 : 16'h0010) * ((t == 8'h00) ? 16'h0100 : {8'h00, t});
	endfunction : period
	task automatic chk(string s, logic [15:0] e, logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	task automatic wr(logic [1:0] ch, logic [7:0] d);
		@(posedge mclk_in);
		channel_select_in <= ch;
		wdata_in <= d;
		write_in <= 1'b1;
		@(posedge mclk_in);
		write_in <= 1'b0;
		wdata_in <= ~d;
	endtask : wr
	task automatic rd(logic [1:0] ch, output logic [7:0] q);
		@(posedge mclk_in);
		channel_select_in <= ch;
		read_in <= 1'b1;
		@(posedge mclk_in);
		read_in <= 1'b0;
		#1;
		q = rdata_out;
	endtask : rd
	task automatic prog(logic [1:0] ch, logic [7:0] k, logic [7:0] t);
		wr(ch, k);
		wr(ch, t);
	endtask : prog
	task automatic wait_pulse(logic [1:0] ch, output logic [15:0] k);
		k = 16'h0000;
		do begin
			@(posedge mclk_in);
			#1;
			k++;
		end while (zero_count_pulse_out[ch] !== 1'b1 && k < 16'h2000);
	endtask : wait_pulse
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		#3000000;
		errors++;
		tally_and_finish();
	end
	initial begin
		void'($urandom(32'h4b4b));
		repeat (16) @(posedge mclk_in);
		rst_n_in <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			c = 2'($urandom_range(2));
			ctl = (i == 1) ? 8'h27 : 8'h07;
			tc = (i == 0) ? 8'($urandom_range(5, 2)) : ((i == 1) ? 8'h01 : 8'h00);
			prog(c, ctl, tc);
			wait_pulse(c, n);
			rd(c, v);
			chk("count", {8'h00, tc}, {8'h00, v});
			wait_pulse(c, n);
			chk("period", period(ctl, tc) - 16'h0002, n);
			$display("timer case %0d done", i);
		end
		prog(2'h1, 8'h57, 8'h03);
		#1 np1 = 0;
		repeat (6) begin
			@(posedge mclk_in);
			edge_input_in[1] <= 1'b1;
			repeat (3) @(posedge mclk_in);
			edge_input_in[1] <= 1'b0;
			repeat ($urandom_range(5, 3)) @(posedge mclk_in);
		end
		repeat (8) @(posedge mclk_in);
		chk("counter", 16'h0002, 16'(np1));
		$display("counter case done");
		prog(2'h2, 8'h0f, 8'h02);
		@(posedge mclk_in);
		edge_input_in[2] <= 1'b1;
		repeat (40) @(posedge mclk_in);
		rd(2'h2, v);
		chk("armed", 16'h0002, {8'h00, v});
		@(posedge mclk_in);
		edge_input_in[2] <= 1'b0;
		wait_pulse(2'h2, n);
		chk("trigger", period(8'h0f, 8'h02) + 16'h0002, n);
		$display("trigger case done");
		chain_priority_in <= 1'b0;
		v = 8'($urandom) & 8'hfe;
		wr(2'h0, v);
		prog(2'h3, 8'h87, 8'h01);
		prog(2'h0, 8'h87, 8'h01);
		repeat (40) @(posedge mclk_in);
		chk("blocked", 16'h0001, 16'(int_request_n_out));
		wr(2'h0, 8'h03);
		chain_priority_in <= 1'b1;
		@(posedge mclk_in);
		#1;
		chk("int", 16'h0000, 16'(int_request_n_out));
		chk("chain", 16'h0000, 16'(chain_priority_out));
		i_host.ack(ok, tc);
		chk("valid", 16'h0001, 16'(ok));
		chk("vector", 16'(v & 8'hf8), 16'(tc));
		i_host.fetch(8'hed);
		i_host.fetch(8'h4d);
		#1;
		chk("return_from_handler", 16'h0000, 16'(int_request_n_out));
		i_host.fetch(8'hed);
		#1;
		chk("prefix", 16'h0001, 16'(chain_priority_out));
		i_host.fetch(8'h00);
		#1;
		chk("after", 16'h0000, 16'(chain_priority_out));
		i_host.ack(ok, tc);
		chk("valid3", 16'h0001, 16'(ok));
		chk("vector3", 16'(v & 8'hf8 | 8'h06), 16'(tc));
		$display("interrupt case done");
		tally_and_finish();
	end
endmodule : four_channel_counter_timer_tb_top
bind quad_timer quad_timer_props i_props (.*);
